//--- src/updown_host.sv
// host controller driving select, step and direction pins of a dual tap device
// Contract
// - host holds select high at power-up
// - deselect without save keeps step low
// - direction may change while selected
// - avoid lowering select while step low
// - select high 10 ms after saving deselect
module updown_host
  import updown_host_pkg::*;
#(
  parameter int unsigned STORE_CYCLES = C_DESEL_STORE
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // command port
  input wire logic cmd_valid_in,
  input wire logic cmd_ch_in,
  input wire logic [1:0] cmd_op_in,
  input wire logic [4:0] cmd_steps_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic [4:0] pos_out,
  output logic pos_ch_out,
  // device pins
  output logic [1:0] select_n_out,
  output logic [1:0] step_n_out,
  output logic [1:0] dir_out
);
  // ==========================================================
  // state
  typedef enum logic [7:0] {
    ST_INIT = 8'b0000_0001,
    ST_IDLE = 8'b0000_0010,
    ST_SETUP = 8'b0000_0100,
    ST_LOW = 8'b0000_1000,
    ST_HIGH = 8'b0001_0000,
    ST_END = 8'b0010_0000,
    ST_DESEL = 8'b0100_0000,
    ST_RDPOS = 8'b1000_0000
  } state_t;

  state_t state_q;
  logic [CNT_W-1:0] tmr_q;
  logic ch_q;
  logic [1:0] op_q;
  logic [4:0] left_q;
  logic [4:0] pos_q;
  logic [CNT_W-1:0] busy_q [2];
  logic wr_en;
  logic [4:0] rd_data;

  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    return CNT_W'(n);
  endfunction

  // saturating tap move, mirrors the device counter
  function automatic logic [4:0] tap_step(input logic [4:0] p, input logic up);
    if (up) begin
      return (p == TAP_MAX) ? p : 5'(p + 5'h01);
    end
    return (p == TAP_RESET) ? p : 5'(p - 5'h01);
  endfunction

  // nosave drops the strobe while still selected, which moves the tap one down, so the mirror follows it
  assign wr_en = ((state_q == ST_LOW) || (state_q == ST_SETUP && op_q == CMD_NOSAVE)) && (tmr_q == '0);

  pos_mem #(.DEPTH(NUM_CH), .WIDTH(TAP_BITS)) i_pos_mem (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wr_en_in(wr_en),
    .wr_addr_in(ch_q),
    .wr_data_in(tap_step(pos_q, op_q == CMD_UP)),
    .rd_addr_in(cmd_ch_in),
    .rd_data_out(rd_data)
  );

  // ==========================================================
  // sequencer
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_q <= ST_INIT;
      tmr_q <= cyc(C_POWERUP);
      ch_q <= 1'b0;
      op_q <= CMD_UP;
      left_q <= 5'h00;
      cmd_ready_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state_q)
        ST_INIT: begin
          // selects stay high through power-up so positions recall
          if (tmr_q == '0) begin
            state_q <= ST_IDLE;
            cmd_ready_out <= 1'b1;
          end else begin
            tmr_q <= tmr_q - 1'b1;
          end
        end
        ST_IDLE: begin
          // reselect waits out the save time of that channel
          if (cmd_valid_in && busy_q[cmd_ch_in] == '0) begin
            ch_q <= cmd_ch_in;
            op_q <= cmd_op_in;
            left_q <= cmd_steps_in;
            cmd_ready_out <= 1'b0;
            state_q <= ST_RDPOS;
          end
        end
        ST_RDPOS: begin
          state_q <= ST_SETUP;
          tmr_q <= cyc(C_SEL_SETUP + C_DIR_SETUP);
        end
        ST_SETUP: begin
          if (tmr_q != '0) begin
            tmr_q <= tmr_q - 1'b1;
          end else if (op_q[1] || left_q == 5'h00) begin
            state_q <= ST_END;
            tmr_q <= cyc(C_STEP_TO_DESEL);
          end else begin
            state_q <= ST_LOW;
            tmr_q <= cyc(C_STEP_LOW);
          end
        end
        ST_LOW: begin
          if (tmr_q != '0) begin
            tmr_q <= tmr_q - 1'b1;
          end else begin
            left_q <= left_q - 5'h01;
            state_q <= ST_HIGH;
            tmr_q <= cyc(C_STEP_HIGH);
          end
        end
        ST_HIGH: begin
          if (tmr_q != '0) begin
            tmr_q <= tmr_q - 1'b1;
          end else if (left_q != 5'h00) begin
            state_q <= ST_LOW;
            tmr_q <= cyc(C_STEP_LOW);
          end else begin
            state_q <= ST_END;
            tmr_q <= cyc(C_STEP_TO_DESEL);
          end
        end
        ST_END: begin
          if (tmr_q != '0) begin
            tmr_q <= tmr_q - 1'b1;
          end else begin
            state_q <= ST_DESEL;
            tmr_q <= cyc(C_DESEL_NOSTORE);
          end
        end
        ST_DESEL: begin
          if (tmr_q != '0) begin
            tmr_q <= tmr_q - 1'b1;
          end else begin
            state_q <= ST_IDLE;
            cmd_ready_out <= 1'b1;
            done_out <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_INIT;
          tmr_q <= cyc(C_POWERUP);
        end
      endcase
    end
  end

  // ==========================================================
  // pin drive, one channel active at a time, others idle high
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      select_n_out <= 2'b11;
      step_n_out <= 2'b11;
      dir_out <= 2'b00;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (c == int'(ch_q) && (state_q == ST_SETUP || state_q == ST_LOW || state_q == ST_HIGH
            || state_q == ST_END)) begin
          select_n_out[c] <= 1'b0;
          dir_out[c] <= (op_q == CMD_UP);
          // nosave: step stays low across select rise
          step_n_out[c] <= !(state_q == ST_LOW || (state_q == ST_END && op_q == CMD_NOSAVE));
        end else if (c == int'(ch_q) && state_q == ST_DESEL) begin
          // save: step high when select rises
          select_n_out[c] <= 1'b1;
          step_n_out[c] <= (op_q == CMD_NOSAVE) ? 1'b0 : 1'b1;
        end else begin
          select_n_out[c] <= 1'b1;
          step_n_out[c] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // save busy timers per channel
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      busy_q[0] <= '0;
      busy_q[1] <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (state_q == ST_END && tmr_q == '0 && c == int'(ch_q) && op_q != CMD_NOSAVE) begin
          busy_q[c] <= CNT_W'(STORE_CYCLES);
        end else if (busy_q[c] != '0) begin
          busy_q[c] <= busy_q[c] - 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // position mirror, tap decode lives in the device
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pos_q <= TAP_RESET;
      pos_out <= TAP_RESET;
      pos_ch_out <= 1'b0;
    end else begin
      if (state_q == ST_RDPOS) begin
        pos_q <= rd_data;
      end else if (wr_en) begin
        pos_q <= tap_step(pos_q, op_q == CMD_UP);
      end
      pos_out <= pos_q;
      pos_ch_out <= ch_q;
    end
  end
endmodule

//--- src/updown_host_pkg.sv
// package: timing constants and commands for the dual up/down tap host
package updown_host_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned NUM_CH = 2;
  localparam int unsigned TAP_BITS = 5;
  localparam logic [4:0] TAP_MAX = 5'h1f;
  localparam logic [4:0] TAP_RESET = 5'h00;
  // times in ns (ms for store deselect)
  localparam int unsigned T_SEL_SETUP_NS = 100;
  localparam int unsigned T_DIR_SETUP_NS = 100;
  localparam int unsigned T_STEP_LOW_NS = 1000;
  localparam int unsigned T_STEP_HIGH_NS = 1000;
  localparam int unsigned T_STEP_TO_DESEL_NS = 1000;
  localparam int unsigned T_DESEL_NOSTORE_NS = 250;
  localparam int unsigned T_DESEL_STORE_MS = 10;
  localparam int unsigned T_POWERUP_NS = 1000;
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * (CLK_HZ / 1_000_000) + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int unsigned C_SEL_SETUP = ns_to_cyc(T_SEL_SETUP_NS);
  localparam int unsigned C_DIR_SETUP = ns_to_cyc(T_DIR_SETUP_NS);
  localparam int unsigned C_STEP_LOW = ns_to_cyc(T_STEP_LOW_NS);
  localparam int unsigned C_STEP_HIGH = ns_to_cyc(T_STEP_HIGH_NS);
  localparam int unsigned C_STEP_TO_DESEL = ns_to_cyc(T_STEP_TO_DESEL_NS);
  localparam int unsigned C_DESEL_NOSTORE = ns_to_cyc(T_DESEL_NOSTORE_NS);
  localparam int unsigned C_POWERUP = ns_to_cyc(T_POWERUP_NS);
  localparam int unsigned C_DESEL_STORE = T_DESEL_STORE_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 20;
  // command codes
  localparam logic [1:0] CMD_UP = 2'h0;
  localparam logic [1:0] CMD_DOWN = 2'h1;
  localparam logic [1:0] CMD_SAVE = 2'h2;
  localparam logic [1:0] CMD_NOSAVE = 2'h3;
endpackage

//--- src/pos_mem.sv
// memory: tracked tap position per channel, registered read
module pos_mem
  import updown_host_pkg::*;
#(
  parameter int unsigned DEPTH = 2,
  parameter int unsigned WIDTH = 5
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  // read port
  input wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem_q[rd_addr_in];
    end
  end
endmodule

//--- verif/tap_dev_model.sv
// behavioural dual tap device standing at the far side of the host
module tap_dev_model #(
  parameter logic [4:0] NV_INIT = 5'h00
) (
  // device pins
  input wire logic [1:0] select_n_in,
  input wire logic [1:0] step_n_in,
  input wire logic [1:0] dir_in,
  // observed state
  output logic [9:0] tap_out,
  output logic [9:0] nv_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // channels
  for (genvar g = 0; g < 2; g++) begin : g_ch
    logic [4:0] tap;
    logic [4:0] nv;
    logic [31:0] hot;
    assign hot = 32'h0000_0001 << tap;
    initial begin
      nv = NV_INIT;
      tap = NV_INIT;
    end
    // floating select counts as deselected
    always @(negedge step_n_in[g]) begin
      if (select_n_in[g] === 1'b0) begin
        if (dir_in[g] === 1'b1 && tap != 5'h1f) tap = tap + 5'h01;
        else if (dir_in[g] === 1'b0 && tap != 5'h00) tap = tap - 5'h01;
      end
    end
    // save when select rises with step high, then standby until reselected
    always @(posedge select_n_in[g]) begin
      if (step_n_in[g] === 1'b1) nv = tap;
    end
    assign tap_out[g*5 +: 5] = tap;
    assign nv_out[g*5 +: 5] = nv;
  end
endmodule

//--- verif/updown_host_checker.sv
// pin-level assertions for the tap host controller
module updown_host_checker #(
  parameter int unsigned STORE_CYCLES = 50
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // watched outputs
  input wire logic done_out,
  input wire logic [1:0] select_n_out,
  input wire logic [1:0] step_n_out,
  input wire logic [1:0] dir_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // ==========================================
  // cycles since last saving deselect of channel 0, saturating
  logic [31:0] hold_q;
  always_ff @(posedge clock_in) begin
    if (rst_in) hold_q <= STORE_CYCLES;
    else if ($rose(select_n_out[0]) && step_n_out[0]) hold_q <= 32'h0000_0000;
    else if (hold_q < STORE_CYCLES) hold_q <= hold_q + 32'h0000_0001;
  end
  // ==========================================
  // assertions
  AST_RST_PINS: assert property ($fell(rst_in) |-> select_n_out == 2'b11 && step_n_out == 2'b11)
    else $error("pins not idle after reset");
  AST_STEP_SEL0: assert property ($fell(step_n_out[0]) |-> !select_n_out[0])
    else $error("step on deselected channel 0");
  AST_STEP_SEL1: assert property ($fell(step_n_out[1]) |-> !select_n_out[1])
    else $error("step on deselected channel 1");
  AST_SEL_SETUP: assert property ($fell(step_n_out[0]) |-> $past(select_n_out[0], 4) == 1'b0)
    else $error("select setup short");
  AST_DIR_SETUP: assert property ($fell(step_n_out[0]) |-> dir_out[0] == $past(dir_out[0], 4))
    else $error("direction changed before step");
  AST_STEP_LOW: assert property ($fell(step_n_out[0]) |-> !step_n_out[0] [*8])
    else $error("step low too short");
  AST_DONE_PULSE: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  AST_SAVE_HOLD: assert property ($fell(select_n_out[0]) |-> hold_q >= STORE_CYCLES - 1)
    else $error("reselect during save");
  cover property ($rose(select_n_out[0]) && step_n_out[0]);
  cover property ($rose(select_n_out[1]) && !step_n_out[1]);
  cover property ($fell(step_n_out[1]));
endmodule

bind updown_host updown_host_checker #(.STORE_CYCLES(STORE_CYCLES)) i_updown_host_checker (
  .clock_in(clock_in), .rst_in(rst_in), .done_out(done_out),
  .select_n_out(select_n_out), .step_n_out(step_n_out), .dir_out(dir_out)
);

//--- verif/updown_host_tb.sv
// self-checking bench for the dual tap host controller
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module updown_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import updown_host_pkg::*;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic cmd_valid_in = 1'b0;
  logic cmd_ch_in = 1'b0;
  logic [1:0] cmd_op_in = 2'h0;
  logic [4:0] cmd_steps_in = 5'h00;
  logic cmd_ready_out, done_out, pos_ch_out;
  logic [4:0] pos_out;
  logic [1:0] select_n_out, step_n_out, dir_out;
  logic [9:0] tap, nv;
  logic [4:0] exp_tap [2] = '{5'h00, 5'h00};
  logic [4:0] exp_nv [2] = '{5'h00, 5'h00};
  logic [10:0] notes [$];
  logic [10:0] note;
  int err_count = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'h5a74_5d70;
  always #12.5 clock_in = ~clock_in;
  // short save timer keeps the run brief
  updown_host #(.STORE_CYCLES(50)) i_updown_host (.clock_in(clock_in), .rst_in(rst_in),
    .cmd_valid_in(cmd_valid_in), .cmd_ch_in(cmd_ch_in), .cmd_op_in(cmd_op_in), .cmd_steps_in(cmd_steps_in),
    .cmd_ready_out(cmd_ready_out), .done_out(done_out), .pos_out(pos_out), .pos_ch_out(pos_ch_out),
    .select_n_out(select_n_out), .step_n_out(step_n_out), .dir_out(dir_out));
  tap_dev_model i_tap_dev_model (.select_n_in(select_n_out), .step_n_in(step_n_out), .dir_in(dir_out),
    .tap_out(tap), .nv_out(nv));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic test_done();
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // driver: notes the expected tap, then issues the command
  task automatic send(input logic ch, input logic [1:0] op, input logic [4:0] st);
    int t;
    t = exp_tap[ch];
    if (op == CMD_UP) t = (t + st > 31) ? 31 : t + st;
    if (op == CMD_DOWN) t = (t < st) ? 0 : t - st;
    // the parking strobe fall of nosave is itself one step down
    if (op == CMD_NOSAVE) t = (t == 0) ? 0 : t - 1;
    exp_tap[ch] = 5'(t);
    if (op != CMD_NOSAVE) exp_nv[ch] = exp_tap[ch];
    notes.push_back({ch, exp_tap[ch], exp_nv[ch]});
    cmd_valid_in = 1'b1;
    cmd_ch_in = ch;
    cmd_op_in = op;
    cmd_steps_in = st;
    // a busy channel holds the command off, so wait for the take
    for (int i = 0; i < 300 && cmd_ready_out !== 1'b0; i++) @(negedge clock_in);
    cmd_valid_in = 1'b0;
    for (int i = 0; i < 5000 && cmd_ready_out !== 1'b1; i++) @(negedge clock_in);
  endtask
  // ==========================================
  // monitor
  always @(negedge clock_in) begin
    if (done_out === 1'b1) begin
      `CHK(notes.size() > 0, 1'b1)
      `CHK(cmd_ready_out, 1'b1)
      note = notes.pop_front();
      `CHK(note[10] ? tap[9:5] : tap[4:0], note[9:5])
      `CHK(note[10] ? nv[9:5] : nv[4:0], note[4:0])
      `CHK({pos_ch_out, pos_out}, note[10:5])
    end
  end
  initial begin
    repeat (20) @(negedge clock_in);
    rst_in = 1'b0;
    for (int i = 0; i < 100 && cmd_ready_out !== 1'b1; i++) @(negedge clock_in);
    send(1'b0, CMD_UP, 5'h1f);
    send(1'b0, CMD_UP, 5'h05);
    send(1'b1, CMD_DOWN, 5'h03);
    send(1'b1, CMD_UP, 5'h09);
    send(1'b1, CMD_DOWN, 5'h02);
    send(1'b0, CMD_NOSAVE, 5'h00);
    send(1'b0, CMD_SAVE, 5'h00);
    for (int i = 0; i < 10; i++) begin
      seed = xorshift(seed);
      send(seed[0], seed[2:1], seed[8:4]);
    end
    repeat (10) @(negedge clock_in);
    test_done();
  end
  initial begin
    repeat (90000) @(posedge clock_in);
    err_count++;
    test_done();
  end
endmodule
